/* core/ser_top.sv */
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ser_consts.svh"

module ser_top
	import ser_pkg::*;
#(
	parameter int LIMIT_W = 8
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [`SER_AW-1:0] i_addr,
	input wire logic [`SER_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [`SER_DW-1:0] o_rdata,
	input wire logic [LIMIT_W-1:0] i_limit_cond,
	input wire logic [`SER_DW-1:0] i_quest_cond,
	input wire ser_opcond_s i_opcond,
	input wire logic [7:0] i_esr_events,
	output logic [7:0] o_stb,
	output logic o_srq,
	output logic o_irq
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Widen a limit-group vector onto the data bus; upper bits read zero
	function automatic logic [`SER_DW-1:0] lim_ext(input logic [LIMIT_W-1:0] v);
		logic [`SER_DW-1:0] r;
		r = `SER_ZERO16;
		r[LIMIT_W-1:0] = v;
		return r;
	endfunction

	// Widen a byte register onto the data bus
	function automatic logic [`SER_DW-1:0] byte_ext(input logic [7:0] v);
		return {`SER_ZERO8, v};
	endfunction

	// Read strobe aimed at one offset
	function automatic logic rd_hit(input logic rd, input logic [`SER_AW-1:0] a,
		input logic [`SER_AW-1:0] off);
		return rd && (a == off);
	endfunction

	// ----------------------------------------
	// Software-written registers
	// ----------------------------------------
	logic [LIMIT_W-1:0] lim_ptr_q; // Limit positive filter
	logic [LIMIT_W-1:0] lim_ntr_q; // Limit negative filter
	logic [LIMIT_W-1:0] lim_ena_q; // Limit enable mask
	logic [`SER_DW-1:0] que_ptr_q; // Questionable positive filter
	logic [`SER_DW-1:0] que_ntr_q; // Questionable negative filter
	logic [`SER_DW-1:0] que_ena_q; // Questionable enable mask
	logic [7:0] ese_q; // Event status enable
	logic [7:0] sre_q; // Service request enable
	logic [`SER_IRQ_W-1:0] irq_mask_q; // Interrupt mask

	// ----------------------------------------
	// Internal state and wires
	// ----------------------------------------
	logic [LIMIT_W-1:0] lim_event; // Limit latched events
	logic lim_summary; // Limit group summary
	logic [`SER_DW-1:0] que_cond; // Questionable condition incl. limit bit
	logic [`SER_DW-1:0] que_event; // Questionable latched events
	logic que_summary; // Questionable summary
	logic [7:0] esr_q; // Event status register
	logic esb; // Event status summary
	logic [7:0] stb_raw; // Status byte without request bit
	logic rqs; // Service request pending
	logic [`SER_DW-1:0] oper_cond; // Operation condition
	logic [`SER_IRQ_W-1:0] irq_set; // Interrupt event pulses
	logic [`SER_IRQ_W-1:0] irq_status; // Sticky interrupt bits
	logic lim_sum_prev_q; // Summary history for edge pulses
	logic que_sum_prev_q;
	logic rqs_prev_q;
	logic [`SER_DW-1:0] rdata_d; // Next read data

	// ----------------------------------------
	// Limit filter registers
	// ----------------------------------------
	// PTR defaults to all ones so rising conditions latch out of reset
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			lim_ptr_q <= LIMIT_W'(`SER_PTR_RST);
			lim_ntr_q <= LIMIT_W'(`SER_NTR_RST);
		end else if (i_wr && i_addr == `SER_LIM_PTR) begin
			lim_ptr_q <= i_wdata[LIMIT_W-1:0];
		end else if (i_wr && i_addr == `SER_LIM_NTR) begin
			lim_ntr_q <= i_wdata[LIMIT_W-1:0];
		end
	end

	// ----------------------------------------
	// Limit enable mask
	// ----------------------------------------
	// Sources not active when the mask is written stay disabled;
	// software must rewrite the mask after activating more sources
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			lim_ena_q <= '0;
		end else if (i_wr && i_addr == `SER_LIM_ENA) begin
			lim_ena_q <= i_wdata[LIMIT_W-1:0] & i_limit_cond;
		end
	end

	// ----------------------------------------
	// Questionable filter and enable registers
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			que_ptr_q <= `SER_PTR_RST;
			que_ntr_q <= `SER_NTR_RST;
			que_ena_q <= `SER_ZERO16;
		end else if (i_wr) begin
			// Each write touches only the addressed register
			case (i_addr)
				`SER_QUE_PTR: begin
					que_ptr_q <= i_wdata;
				end
				`SER_QUE_NTR: begin
					que_ntr_q <= i_wdata;
				end
				`SER_QUE_ENA: begin
					que_ena_q <= i_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Status byte enables and interrupt mask
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			ese_q <= `SER_ZERO8;
			sre_q <= `SER_ZERO8;
			irq_mask_q <= '0;
		end else if (i_wr) begin
			case (i_addr)
				`SER_ESE: begin
					ese_q <= i_wdata[7:0];
				end
				`SER_SRE: begin
					// The request bit itself cannot enable a request
					sre_q <= i_wdata[7:0] & ~(8'h01 << `SER_STB_RQS_BIT);
				end
				`SER_IRQ_MASK: begin
					irq_mask_q <= i_wdata[`SER_IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Limit group
	// ----------------------------------------
	// event read clears limit group
	ser_group #(
		.W(LIMIT_W)
	) u_limit (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_cond(i_limit_cond),
		.i_ptr(lim_ptr_q),
		.i_ntr(lim_ntr_q),
		.i_enable(lim_ena_q),
		.i_clear(rd_hit(i_rd, i_addr, `SER_LIM_EVT)),
		.o_event(lim_event),
		.o_summary(lim_summary)
	);

	// ----------------------------------------
	// Questionable group
	// ----------------------------------------
	always_comb begin
		que_cond = i_quest_cond;
		que_cond[`SER_QUE_LIMIT_BIT] = lim_summary;
	end

	ser_group #(
		.W(`SER_DW)
	) u_quest (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_cond(que_cond),
		.i_ptr(que_ptr_q),
		.i_ntr(que_ntr_q),
		.i_enable(que_ena_q),
		.i_clear(rd_hit(i_rd, i_addr, `SER_QUE_EVT)),
		.o_event(que_event),
		.o_summary(que_summary)
	);

	// ----------------------------------------
	// Operation condition
	// ----------------------------------------
	// live acquisition state bits
	always_comb begin
		oper_cond = `SER_ZERO16;
		oper_cond[`SER_OPER_MEAS_BIT] = i_opcond.measuring;
		oper_cond[`SER_OPER_WAIT_BIT] = i_opcond.awaiting_trigger_flag;
		oper_cond[`SER_OPER_TRIG_BIT] = i_opcond.triggered;
	end

	// ----------------------------------------
	// Event status register
	// ----------------------------------------
	// Completion and error pulses from the instrument latch here;
	// long jobs are polled through this register rather than blocking
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			esr_q <= `SER_ZERO8;
		end else begin
			esr_q <= (rd_hit(i_rd, i_addr, `SER_ESR) ? `SER_ZERO8 : esr_q) | i_esr_events;
		end
	end

	assign esb = |(esr_q & ese_q);

	// ----------------------------------------
	// Status byte and service request
	// ----------------------------------------
	always_comb begin
		stb_raw = `SER_ZERO8;
		stb_raw[`SER_STB_QUES_BIT] = que_summary;
		stb_raw[`SER_STB_ESB_BIT] = esb;
		rqs = |(stb_raw & sre_q);
	end

	// Status byte is registered so the output is glitch free
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_stb <= `SER_ZERO8;
			o_srq <= 1'b0;
		end else begin
			o_stb <= stb_raw | (rqs ? (8'h01 << `SER_STB_RQS_BIT) : `SER_ZERO8);
			o_srq <= rqs;
		end
	end

	// ----------------------------------------
	// Interrupt events
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			lim_sum_prev_q <= 1'b0;
			que_sum_prev_q <= 1'b0;
			rqs_prev_q <= 1'b0;
		end else begin
			lim_sum_prev_q <= lim_summary;
			que_sum_prev_q <= que_summary;
			rqs_prev_q <= rqs;
		end
	end

	// Summary rises become one-cycle pulses
	always_comb begin
		irq_set = '0;
		irq_set[`SER_IRQ_LIM_BIT] = lim_summary & ~lim_sum_prev_q;
		irq_set[`SER_IRQ_QUES_BIT] = que_summary & ~que_sum_prev_q;
		irq_set[`SER_IRQ_SRQ_BIT] = rqs & ~rqs_prev_q;
	end

	ser_irq #(
		.W(`SER_IRQ_W)
	) u_irq (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_set(irq_set),
		.i_clr_wr(i_wr && i_addr == `SER_IRQ_STAT),
		.i_clr_data(i_wdata[`SER_IRQ_W-1:0]),
		.i_mask(irq_mask_q),
		.o_status(irq_status),
		.o_irq(o_irq)
	);

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		rdata_d = `SER_ZERO16;
		case (i_addr)
			// condition read live, no side effect
			`SER_LIM_COND: begin
				rdata_d = lim_ext(i_limit_cond);
			end
			`SER_LIM_PTR: begin
				rdata_d = lim_ext(lim_ptr_q);
			end
			`SER_LIM_NTR: begin
				rdata_d = lim_ext(lim_ntr_q);
			end
			`SER_LIM_EVT: begin
				rdata_d = lim_ext(lim_event);
			end
			`SER_LIM_ENA: begin
				rdata_d = lim_ext(lim_ena_q);
			end
			`SER_QUE_COND: begin
				rdata_d = que_cond;
			end
			`SER_QUE_PTR: begin
				rdata_d = que_ptr_q;
			end
			`SER_QUE_NTR: begin
				rdata_d = que_ntr_q;
			end
			`SER_QUE_EVT: begin
				rdata_d = que_event;
			end
			`SER_QUE_ENA: begin
				rdata_d = que_ena_q;
			end
			`SER_OPER_COND: begin
				rdata_d = oper_cond;
			end
			`SER_ESR: begin
				rdata_d = byte_ext(esr_q);
			end
			`SER_ESE: begin
				rdata_d = byte_ext(ese_q);
			end
			`SER_SRE: begin
				rdata_d = byte_ext(sre_q);
			end
			`SER_STB: begin
				rdata_d = byte_ext(stb_raw | (rqs ? (8'h01 << `SER_STB_RQS_BIT) : `SER_ZERO8));
			end
			`SER_IRQ_STAT: begin
				rdata_d = {{(`SER_DW-`SER_IRQ_W){1'b0}}, irq_status};
			end
			`SER_IRQ_MASK: begin
				rdata_d = {{(`SER_DW-`SER_IRQ_W){1'b0}}, irq_mask_q};
			end
			// Unmapped offsets read zero
			default: begin
				rdata_d = `SER_ZERO16;
			end
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_rdata <= `SER_ZERO16;
		end else if (i_rd) begin
			o_rdata <= rdata_d;
		end else begin
			o_rdata <= `SER_ZERO16;
		end
	end
endmodule
`default_nettype wire

/* core/ser_consts.svh */
`ifndef SER_CONSTS_SVH
`define SER_CONSTS_SVH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define SER_AW 8
`define SER_DW 16

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SER_LIM_COND 8'h00
`define SER_LIM_PTR 8'h04
`define SER_LIM_NTR 8'h08
`define SER_LIM_EVT 8'h0c
`define SER_LIM_ENA 8'h10
`define SER_QUE_COND 8'h14
`define SER_QUE_PTR 8'h18
`define SER_QUE_NTR 8'h1c
`define SER_QUE_EVT 8'h20
`define SER_QUE_ENA 8'h24
`define SER_OPER_COND 8'h28
`define SER_ESR 8'h2c
`define SER_ESE 8'h30
`define SER_SRE 8'h34
`define SER_STB 8'h38
`define SER_IRQ_STAT 8'h3c
`define SER_IRQ_MASK 8'h40

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SER_QUE_LIMIT_BIT 9
`define SER_STB_QUES_BIT 3
`define SER_STB_ESB_BIT 5
`define SER_STB_RQS_BIT 6
`define SER_OPER_MEAS_BIT 4
`define SER_OPER_WAIT_BIT 5
`define SER_OPER_TRIG_BIT 6
`define SER_IRQ_LIM_BIT 0
`define SER_IRQ_QUES_BIT 1
`define SER_IRQ_SRQ_BIT 2
`define SER_IRQ_W 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SER_PTR_RST 16'hffff
`define SER_NTR_RST 16'h0000
`define SER_ZERO16 16'h0000
`define SER_ZERO8 8'h00

`endif

/* core/ser_pkg.sv */
package ser_pkg;
	// Live acquisition state that feeds the operation condition part
	typedef struct packed {
		logic measuring;
		logic awaiting_trigger_flag;
		logic triggered;
	} ser_opcond_s;
endpackage

/* core/ser_group.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ser_consts.svh"

// One status group: transition filters, latched event part, enable summary
module ser_group #(
	parameter int W = 8
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [W-1:0] i_cond,
	input wire logic [W-1:0] i_ptr,
	input wire logic [W-1:0] i_ntr,
	input wire logic [W-1:0] i_enable,
	input wire logic i_clear,
	output logic [W-1:0] o_event,
	output logic o_summary
);
	logic [W-1:0] cond_prev_q; // Condition one clock ago
	logic [W-1:0] set_now; // Filtered edges this cycle

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	// compare with registered value
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			cond_prev_q <= '0;
		end else begin
			cond_prev_q <= i_cond;
		end
	end

	always_comb begin
		set_now = i_cond & ~cond_prev_q & i_ptr;
		set_now = set_now | (~i_cond & cond_prev_q & i_ntr);
	end

	// ----------------------------------------
	// Latched event part
	// ----------------------------------------
	// read clears; set wins over clear
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_event <= '0;
		end else begin
			// only fresh edges set bits again
			o_event <= (i_clear ? '0 : o_event) | set_now;
		end
	end

	assign o_summary = |(o_event & i_enable);
endmodule
`default_nettype wire

/* core/ser_irq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ser_consts.svh"

// Sticky interrupt status, cleared by writing ones, gated by a mask
module ser_irq #(
	parameter int W = 3
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [W-1:0] i_set,
	input wire logic i_clr_wr,
	input wire logic [W-1:0] i_clr_data,
	input wire logic [W-1:0] i_mask,
	output logic [W-1:0] o_status,
	output logic o_irq
);
	// A set in the clearing cycle survives, so no event is lost
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_status <= '0;
		end else begin
			o_status <= (o_status & ~(i_clr_wr ? i_clr_data : '0)) | i_set;
		end
	end

	// Level output while any unmasked bit stands
	assign o_irq = |(o_status & i_mask);
endmodule
`default_nettype wire

/* verification/ser_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ser_consts.svh"
// --------
// Port checks
// --------
module ser_top_chk
	import ser_pkg::*;
#(
	parameter int LIMIT_W = 8
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [`SER_AW-1:0] i_addr,
	input wire logic [`SER_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [`SER_DW-1:0] o_rdata,
	input wire logic [LIMIT_W-1:0] i_limit_cond,
	input wire logic [`SER_DW-1:0] i_quest_cond,
	input wire ser_opcond_s i_opcond,
	input wire logic [7:0] i_esr_events,
	input wire logic [7:0] o_stb,
	input wire logic o_srq,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_reset);
	// Event read with no fresh limit edge
	sequence s_lim_rd;
		i_rd && i_addr == `SER_LIM_EVT && $stable(i_limit_cond);
	endsequence
	// Status read with no event input
	sequence s_esr_rd;
		i_rd && i_addr == `SER_ESR && i_esr_events == 8'h00;
	endsequence
	a_lim_evt_clear: assert property (s_lim_rd ##1 $stable(i_limit_cond) ##1 s_lim_rd
		|=> o_rdata == 16'h0000) else $error("limit events kept after read");
	a_esr_clear: assert property (s_esr_rd ##1 i_esr_events == 8'h00 ##1 s_esr_rd
		|=> o_rdata == 16'h0000) else $error("event status kept after read");
	a_oper_bits: assert property (i_rd && i_addr == `SER_OPER_COND && $stable(i_opcond)
		|=> o_rdata == {9'h000, $past(i_opcond.triggered),
		$past(i_opcond.awaiting_trigger_flag), $past(i_opcond.measuring), 4'h0})
		else $error("operation condition wrong");
	a_lim_cond: assert property (i_rd && i_addr == `SER_LIM_COND && $stable(i_limit_cond)
		|=> o_rdata == 16'($past(i_limit_cond))) else $error("limit condition wrong");
	a_srq_bit: assert property (o_srq == o_stb[`SER_STB_RQS_BIT] && (!o_srq
		|| o_stb[`SER_STB_QUES_BIT] || o_stb[`SER_STB_ESB_BIT]))
		else $error("request level and status byte differ");
	a_stb_read: assert property (i_rd && i_addr == `SER_STB
		|=> o_rdata == {8'h00, o_stb}) else $error("status byte read wrong");
	// Read data idle rule
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
		else $error("read data outside answer cycle");
	// Unmapped place reads zero
	a_unmapped: assert property (i_rd && i_addr > 8'h40 |=> o_rdata == 16'h0000)
		else $error("unmapped read not zero");
	c_irq: cover property (o_irq && !i_wr && i_quest_cond == 16'h0000);
endmodule
bind ser_top ser_top_chk #(.LIMIT_W(LIMIT_W)) u_chk (.i_clock(i_clock), .i_reset(i_reset),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_limit_cond(i_limit_cond), .i_quest_cond(i_quest_cond), .i_opcond(i_opcond),
	.i_esr_events(i_esr_events), .o_stb(o_stb), .o_srq(o_srq), .o_irq(o_irq));
`default_nettype wire

/* verification/ser_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ser_consts.svh"
// --------
// Remote host on the register port
// --------
module ser_host (
	input wire logic i_clock,
	input wire logic [`SER_DW-1:0] i_rdata,
	output logic [`SER_AW-1:0] o_addr,
	output logic [`SER_DW-1:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	// Idle bus at time zero
	initial begin
		o_addr = 8'h00;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// One-cycle write; released fields show junk, not the old value
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clock);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clock);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
		#1;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clock);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clock);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
	endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ser_consts.svh"
module testbench
	import ser_pkg::*;
;
	logic i_clock;
	logic i_reset;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] quest;
	logic wr;
	logic rd;
	logic srq;
	logic irq;
	logic [7:0] lim;
	logic [7:0] esr;
	logic [7:0] stb;
	ser_opcond_s op;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	integer seed = 32'h8a76;
	logic [15:0] r;
	// Reset table: offsets and their values, last one unmapped
	logic [7:0] ra [9] = '{`SER_LIM_PTR, `SER_QUE_PTR, `SER_LIM_NTR, `SER_QUE_NTR,
		`SER_LIM_ENA, `SER_QUE_ENA, `SER_SRE, `SER_STB, 8'h44};
	logic [15:0] rv [9] = '{16'h00ff, 16'hffff, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	ser_top #(.LIMIT_W(8)) u_dut (.i_clock(i_clock), .i_reset(i_reset), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_limit_cond(lim),
		.i_quest_cond(quest), .i_opcond(op), .i_esr_events(esr), .o_stb(stb),
		.o_srq(srq), .o_irq(irq));
	ser_host u_host (.i_clock(i_clock), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd));
	// --------
	// Helpers
	// --------
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	function automatic logic [15:0] exp_oper(input logic [2:0] s);
		return {9'h000, s[0], s[1], s[2], 4'h0};
	endfunction
	// Enable keeps only sources live at write time
	function automatic logic [15:0] exp_ena(input logic [15:0] w, input logic [7:0] c);
		return {8'h00, w[7:0] & c};
	endfunction
	task automatic chk_rd(input logic [7:0] a, input logic [15:0] x);
		logic [15:0] d;
		u_host.rd_reg(a, d);
		comparisons++;
		if (d !== x) begin
			error_cnt++;
			$display("[ERR] reg %h exp %h got %h", a, x, d);
		end
	endtask
	task automatic chk_pin(input string n, input logic [7:0] x, input logic [7:0] g);
		comparisons++;
		if (g !== x) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Hang guard: whole run needs far fewer cycles
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	// --------
	// Main sequence
	// --------
	initial begin
		i_reset <= 1'b1;
		lim <= 8'h00;
		quest <= 16'h0000;
		op <= ser_opcond_s'(3'h0);
		esr <= 8'h00;
		repeat (6) @(posedge i_clock);
		i_reset <= 1'b0;
		// Read-only byte ignores writes, then reset values
		u_host.wr_reg(`SER_STB, 16'hffff);
		for (int i = 0; i < 9; i++) begin
			chk_rd(ra[i], rv[i]);
		end
		$display("test reset done");
		r = 16'($random(seed)) | 16'h0001;
		@(posedge i_clock);
		lim <= r[7:0];
		quest <= (16'($random(seed)) & 16'hfdff) | 16'h0001;
		wait_clk(3);
		chk_rd(`SER_LIM_COND, {8'h00, lim});
		chk_rd(`SER_QUE_COND, quest);
		chk_rd(`SER_LIM_EVT, {8'h00, lim});
		chk_rd(`SER_LIM_EVT, 16'h0000);
		chk_rd(`SER_QUE_EVT, quest);
		u_host.wr_reg(`SER_LIM_PTR, 16'h0000);
		u_host.wr_reg(`SER_LIM_NTR, 16'h00ff);
		@(posedge i_clock);
		lim <= 8'h00;
		quest <= 16'h0000;
		wait_clk(3);
		chk_rd(`SER_LIM_EVT, {8'h00, r[7:0]});
		chk_rd(`SER_QUE_EVT, 16'h0000);
		u_host.wr_reg(`SER_LIM_PTR, 16'h00ff);
		u_host.wr_reg(`SER_LIM_NTR, 16'h0000);
		$display("test filters done");
		for (int i = 0; i < 8; i++) begin
			@(posedge i_clock);
			op <= ser_opcond_s'(i[2:0]);
			chk_rd(`SER_OPER_COND, exp_oper(i[2:0]));
		end
		$display("test operation done");
		for (int i = 0; i < 4; i++) begin
			r = 16'($random(seed)) | 16'h0001;
			@(posedge i_clock);
			esr <= r[7:0];
			@(posedge i_clock);
			esr <= 8'h00;
			chk_rd(`SER_ESR, {8'h00, r[7:0]});
			chk_rd(`SER_ESR, 16'h0000);
		end
		$display("test event status done");
		// Full chain: limit group up to the request bit
		u_host.wr_reg(`SER_IRQ_MASK, 16'h0007);
		u_host.wr_reg(`SER_SRE, 16'h0008);
		u_host.wr_reg(`SER_QUE_ENA, 16'h0200);
		@(posedge i_clock);
		lim <= 8'h07;
		wait_clk(3);
		u_host.wr_reg(`SER_LIM_ENA, 16'hffff);
		chk_rd(`SER_LIM_ENA, exp_ena(16'hffff, lim));
		wait_clk(8);
		chk_pin("stb", 8'h48, stb);
		chk_pin("srq", 8'h01, {7'h00, srq});
		chk_rd(`SER_STB, 16'h0048);
		chk_rd(`SER_QUE_EVT, 16'h0200);
		chk_rd(`SER_QUE_EVT, 16'h0000);
		chk_pin("irq", 8'h01, {7'h00, irq});
		chk_rd(`SER_IRQ_STAT, 16'h0007);
		u_host.wr_reg(`SER_IRQ_MASK, 16'h0000);
		chk_pin("irq", 8'h00, {7'h00, irq});
		u_host.wr_reg(`SER_IRQ_MASK, 16'h0007);
		chk_pin("irq", 8'h01, {7'h00, irq});
		u_host.wr_reg(`SER_IRQ_STAT, 16'h0007);
		chk_pin("irq", 8'h00, {7'h00, irq});
		// New edge lands on the clearing read
		fork
			chk_rd(`SER_LIM_EVT, 16'h0007);
			begin
				@(posedge i_clock);
				lim <= 8'h0f;
			end
		join
		chk_rd(`SER_LIM_EVT, 16'h0008);
		wait_clk(6);
		chk_pin("stb", 8'h00, stb);
		chk_pin("srq", 8'h00, {7'h00, srq});
		// Event status summary on bit 5; the request bit cannot be enabled
		u_host.wr_reg(`SER_ESE, 16'h0001);
		u_host.wr_reg(`SER_SRE, 16'h0060);
		chk_rd(`SER_SRE, 16'h0020);
		@(posedge i_clock);
		esr <= 8'h01;
		@(posedge i_clock);
		esr <= 8'h00;
		wait_clk(3);
		chk_pin("stb", 8'h60, stb);
		chk_rd(`SER_ESR, 16'h0001);
		wait_clk(2);
		chk_pin("stb", 8'h00, stb);
		$display("test summary done");
		finish_test();
	end
endmodule
`default_nettype wire
